// *** logic/dbf_pkg.sv ***
// dbf_pkg: constants and types shared by the debug port front end.
// assumes: debug clock and system clock are unrelated in phase.
package dbf_pkg;
    // synchroniser depth for pins and cross-domain levels
    localparam int SYNC_STAGES = 3;
    // mode switch sequence on the mode-select line
    localparam logic [5:0] MODE_HI_MIN = 6'h33;
    localparam logic [4:0] SEQ_LEN = 5'h10;
    localparam logic [15:0] SWD_SEL_SEQ = 16'h79e7;
    localparam logic [15:0] JTAG_SEL_SEQ = 16'h3ce7;
    // mode-select high clocks that reach test-logic-reset from any state
    localparam int TLR_TMS_CLKS = 5;
    // reset values
    localparam logic MODE_RST_SWD = 1'b0;
    localparam logic TRACE_FMT_RST_NRZ = 1'b0;
    localparam logic PRESENT_RST = 1'b0;
    localparam logic HALT_RST = 1'b0;

    typedef enum logic [15:0] {
        ST_TLR = 16'h0001,
        ST_RTI = 16'h0002,
        ST_SEL_DR = 16'h0004,
        ST_CAP_DR = 16'h0008,
        ST_SHIFT_DR = 16'h0010,
        ST_EXIT1_DR = 16'h0020,
        ST_PAUSE_DR = 16'h0040,
        ST_EXIT2_DR = 16'h0080,
        ST_UPD_DR = 16'h0100,
        ST_SEL_IR = 16'h0200,
        ST_CAP_IR = 16'h0400,
        ST_SHIFT_IR = 16'h0800,
        ST_EXIT1_IR = 16'h1000,
        ST_PAUSE_IR = 16'h2000,
        ST_EXIT2_IR = 16'h4000,
        ST_UPD_IR = 16'h8000
    } dbf_tap_state_t;
endpackage : dbf_pkg

// *** logic/dbf_sync.sv ***
// dbf_sync: three-stage synchroniser with agreement filter.
// assumes: inputs may change at any time relative to clk.
`timescale 1ns/1ps
module dbf_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // async in, stable out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] q_ff;
    logic [W-1:0] nxt_q;

    // a bit changes only once stages two and three agree
    always_comb begin
        for (int i = 0; i < W; i++) begin
            nxt_q[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : q_ff[i];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_ff <= RST_VAL;
            s2_ff <= RST_VAL;
            s3_ff <= RST_VAL;
            q_ff <= RST_VAL;
        end else begin
            s1_ff <= d;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            q_ff <= nxt_q;
        end
    end

    assign q = q_ff;
endmodule : dbf_sync

// *** logic/dbf_tap.sv ***
// dbf_tap: test access port state machine on the debug clock.
// assumes: mode-select is launched by the probe relative to tck.
`timescale 1ns/1ps
module dbf_tap (
    // debug clock domain
    input wire logic tck,
    input wire logic arst_n,
    input wire logic tms,
    // state
    output dbf_pkg::dbf_tap_state_t state,
    output logic in_tlr
);
    dbf_pkg::dbf_tap_state_t state_ff;
    dbf_pkg::dbf_tap_state_t nxt_state;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            dbf_pkg::ST_TLR: nxt_state = tms ? dbf_pkg::ST_TLR : dbf_pkg::ST_RTI;
            dbf_pkg::ST_RTI: nxt_state = tms ? dbf_pkg::ST_SEL_DR : dbf_pkg::ST_RTI;
            dbf_pkg::ST_SEL_DR: nxt_state = tms ? dbf_pkg::ST_SEL_IR : dbf_pkg::ST_CAP_DR;
            dbf_pkg::ST_CAP_DR: nxt_state = tms ? dbf_pkg::ST_EXIT1_DR : dbf_pkg::ST_SHIFT_DR;
            dbf_pkg::ST_SHIFT_DR: nxt_state = tms ? dbf_pkg::ST_EXIT1_DR : dbf_pkg::ST_SHIFT_DR;
            dbf_pkg::ST_EXIT1_DR: nxt_state = tms ? dbf_pkg::ST_UPD_DR : dbf_pkg::ST_PAUSE_DR;
            dbf_pkg::ST_PAUSE_DR: nxt_state = tms ? dbf_pkg::ST_EXIT2_DR : dbf_pkg::ST_PAUSE_DR;
            dbf_pkg::ST_EXIT2_DR: nxt_state = tms ? dbf_pkg::ST_UPD_DR : dbf_pkg::ST_SHIFT_DR;
            dbf_pkg::ST_UPD_DR: nxt_state = tms ? dbf_pkg::ST_SEL_DR : dbf_pkg::ST_RTI;
            dbf_pkg::ST_SEL_IR: nxt_state = tms ? dbf_pkg::ST_TLR : dbf_pkg::ST_CAP_IR;
            dbf_pkg::ST_CAP_IR: nxt_state = tms ? dbf_pkg::ST_EXIT1_IR : dbf_pkg::ST_SHIFT_IR;
            dbf_pkg::ST_SHIFT_IR: nxt_state = tms ? dbf_pkg::ST_EXIT1_IR : dbf_pkg::ST_SHIFT_IR;
            dbf_pkg::ST_EXIT1_IR: nxt_state = tms ? dbf_pkg::ST_UPD_IR : dbf_pkg::ST_PAUSE_IR;
            dbf_pkg::ST_PAUSE_IR: nxt_state = tms ? dbf_pkg::ST_EXIT2_IR : dbf_pkg::ST_PAUSE_IR;
            dbf_pkg::ST_EXIT2_IR: nxt_state = tms ? dbf_pkg::ST_UPD_IR : dbf_pkg::ST_SHIFT_IR;
            dbf_pkg::ST_UPD_IR: nxt_state = tms ? dbf_pkg::ST_SEL_DR : dbf_pkg::ST_RTI;
            default: nxt_state = dbf_pkg::ST_TLR;
        endcase
    end

    always_ff @(posedge tck or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= dbf_pkg::ST_TLR;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign state = state_ff;
    // port logic held in reset while here
    assign in_tlr = (state_ff == dbf_pkg::ST_TLR); // RULE8

    // five high mode-select clocks always land in the reset state
    chk_tlr_after_ones: assert property ( // RULE9
        @(posedge tck) disable iff (!arst_n)
        tms [*5] |-> ##1 in_tlr)
        else $error("tap not in test-logic-reset after five high tms clocks");
endmodule : dbf_tap

// *** logic/dbf_front_end.sv ***
// dbf_front_end: hot-plug detection, pin takeover and core hold for the debug port.
// assumes: tck is both a clock port and a pin level; the probe drives it (stopped
// outside sessions), the debug port core sits outside on the tck domain.
// Overview of operation
// [RULE1] the debug clock pin is used only by the debug port, never by gpio
// [RULE2] after reset all other debug pins stay gpio until a debugger shows up
// [RULE3] first tck falling edge with external reset released marks debugger present
// [RULE4] once present, debug pins are forced to debug use over other owners
// [RULE5] detection never touches core execution or its reset
// [RULE6] serial-wire mode hands data-in and data-out pins back to gpio
// [RULE7] data-out carries tdo in jtag mode, may carry trace in serial-wire mode
// [RULE8] port logic held in sync reset while tap sits in test-logic-reset
// [RULE9] probe holds mode-select high five clocks to reach test-logic-reset
// [RULE10] armed halt keeps core in reset after external reset release
// [RULE11] the probe supplies the debug clock, sole clock of the debug port
// [RULE12] debug access requests cpu clock restore from the power manager
// [RULE13] cpu clock runs from system rc clock while external reset applied
// [RULE14] debugger present keeps the connection and power on
// [RULE15] hot-plug detection works in all modes except deepest backup mode
// [RULE16] trace output format resets to manchester, nrz selectable
// [RULE17] tck held low until reset release requests the core halt
// [RULE18] jtag after reset; 0x79e7 after long high run selects serial-wire
// [RULE19] present and pin takeover latch until device reset, not set during reset
`timescale 1ns/1ps
module dbf_front_end (
    // system clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // debug clock from the probe
    input wire logic tck,
    // external reset pin level, low = asserted
    input wire logic rst_pin_n,
    // shared pads
    input wire logic tms_pad_i,
    output logic tms_pad_o,
    output logic tms_pad_oe,
    input wire logic tdi_pad_i,
    output logic tdi_pad_o,
    output logic tdi_pad_oe,
    output logic tdo_pad_o,
    output logic tdo_pad_oe,
    // gpio side of the shared pads
    input wire logic gpio_tms_o,
    input wire logic gpio_tms_oe,
    input wire logic gpio_tdi_o,
    input wire logic gpio_tdi_oe,
    input wire logic gpio_tdo_o,
    input wire logic gpio_tdo_oe,
    // debug port core, tck domain
    input wire logic dp_tdo,
    input wire logic dp_tdo_oe,
    input wire logic dp_swdio_o,
    input wire logic dp_swdio_oe,
    input wire logic dp_ap_access,
    output logic dp_tdi,
    output logic dp_sync_rst,
    output logic dp_swd_mode,
    output dbf_pkg::dbf_tap_state_t dp_tap_state,
    // trace unit
    input wire logic trace_bit,
    input wire logic trace_en,
    input wire logic trace_fmt_wr,
    input wire logic trace_fmt_nrz_req,
    output logic trace_fmt_nrz,
    // system manager and power
    input wire logic backup_mode,
    input wire logic core_rst_release,
    output logic dbg_present,
    output logic core_rst_n,
    output logic cpu_clk_restore,
    output logic cpu_clk_system_rc_clock,
    output logic power_keep
);
    // tck domain state
    logic tap_tlr;
    logic [5:0] hi_cnt_ff;
    logic [5:0] nxt_hi_cnt;
    logic armed_ff;
    logic nxt_armed;
    logic [4:0] bit_cnt_ff;
    logic [4:0] nxt_bit_cnt;
    logic [15:0] seq_ff;
    logic [15:0] nxt_seq;
    logic [15:0] seq_now;
    logic swd_ff;
    logic nxt_swd;

    // sys domain state
    logic tck_st;
    logic rst_st;
    logic swd_s;
    logic acc_s;
    logic tck_q_ff;
    logic rst_q_ff;
    logic present_ff;
    logic nxt_present;
    logic halt_ff;
    logic nxt_halt;
    logic core_rst_n_ff;
    logic nxt_core_rst_n;
    logic own_tms_ff;
    logic own_tdi_ff;
    logic own_tdo_ff;
    logic trace_route_ff;
    logic nxt_own_tms;
    logic nxt_own_tdi;
    logic nxt_own_tdo;
    logic nxt_trace_route;
    logic fmt_ff;
    logic nxt_fmt;
    logic restore_ff;
    logic nxt_restore;
    logic system_rc_clock_ff;
    logic nxt_system_rc_clock;
    logic keep_ff;
    logic nxt_keep;
    logic tck_fall;
    logic rst_rel;

    // the whole tck side runs on the probe's clock only
    dbf_tap u_tap ( // RULE11
        .tck(tck),
        .arst_n(arst_n),
        .tms(tms_pad_i),
        .state(dp_tap_state),
        .in_tlr(tap_tlr)
    );

    assign dp_sync_rst = tap_tlr; // RULE8

    // mode select watcher; kept out of the tlr reset since the high run itself
    // drives the tap into tlr
    always_comb begin
        seq_now = {seq_ff[14:0], tms_pad_i};
        nxt_seq = seq_ff;
        nxt_bit_cnt = bit_cnt_ff;
        nxt_armed = armed_ff;
        nxt_swd = swd_ff;
        if (tms_pad_i) begin
            nxt_hi_cnt = (hi_cnt_ff >= dbf_pkg::MODE_HI_MIN) ? hi_cnt_ff : 6'(hi_cnt_ff + 6'h01);
        end else begin
            nxt_hi_cnt = 6'h00;
        end
        if (armed_ff) begin
            nxt_seq = seq_now;
            nxt_bit_cnt = 5'(bit_cnt_ff + 5'h01);
            if (bit_cnt_ff == 5'(dbf_pkg::SEQ_LEN - 5'h01)) begin
                nxt_armed = 1'b0;
                if (seq_now == dbf_pkg::SWD_SEL_SEQ) begin
                    nxt_swd = 1'b1; // RULE18
                end else if (seq_now == dbf_pkg::JTAG_SEL_SEQ) begin
                    nxt_swd = 1'b0;
                end
            end
        end else if (!tms_pad_i && hi_cnt_ff >= dbf_pkg::MODE_HI_MIN) begin
            nxt_armed = 1'b1;
            nxt_seq = seq_now;
            nxt_bit_cnt = 5'h01;
        end
    end

    always_ff @(posedge tck or negedge arst_n) begin
        if (!arst_n) begin
            hi_cnt_ff <= 6'h00;
            armed_ff <= 1'b0;
            bit_cnt_ff <= 5'h00;
            seq_ff <= 16'h0000;
            swd_ff <= dbf_pkg::MODE_RST_SWD; // RULE18
        end else begin
            hi_cnt_ff <= nxt_hi_cnt;
            armed_ff <= nxt_armed;
            bit_cnt_ff <= nxt_bit_cnt;
            seq_ff <= nxt_seq;
            swd_ff <= nxt_swd;
        end
    end

    assign dp_swd_mode = swd_ff;

    // pin levels into the system domain; tck is only sampled, never driven
    dbf_sync #(.W(2), .RST_VAL(2'b10)) u_pin_sync ( // RULE1
        .clk(sys_clk),
        .arst_n(arst_n),
        .d({tck, rst_pin_n}),
        .q({tck_st, rst_st})
    );

    // tck domain levels crossing into the system domain
    dbf_sync #(.W(2), .RST_VAL(2'b00)) u_dom_sync (
        .clk(sys_clk),
        .arst_n(arst_n),
        .d({swd_ff, dp_ap_access}),
        .q({swd_s, acc_s})
    );

    assign tck_fall = tck_q_ff && !tck_st;
    assign rst_rel = rst_st && !rst_q_ff;

    always_comb begin
        // sticky; an edge while reset is held or in backup is ignored
        nxt_present = present_ff || (tck_fall && rst_st && !backup_mode); // RULE3 RULE15 RULE19
        // set wins over the release pulse
        nxt_halt = halt_ff;
        if (core_rst_release) begin
            nxt_halt = 1'b0;
        end
        if (rst_rel && !tck_st) begin
            nxt_halt = 1'b1; // RULE17 RULE10
        end
        // detection alone never feeds the core reset
        nxt_core_rst_n = rst_st && !nxt_halt; // RULE5
        nxt_own_tms = nxt_present; // RULE2 RULE4
        nxt_own_tdi = nxt_present && !swd_s; // RULE6
        nxt_own_tdo = nxt_present && (!swd_s || trace_en); // RULE6 RULE7
        nxt_trace_route = nxt_present && swd_s && trace_en; // RULE7
        nxt_fmt = trace_fmt_wr ? trace_fmt_nrz_req : fmt_ff; // RULE16
        nxt_restore = nxt_present && acc_s; // RULE12
        nxt_system_rc_clock = !rst_st; // RULE13
        nxt_keep = nxt_present; // RULE14
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            tck_q_ff <= 1'b1;
            rst_q_ff <= 1'b0;
            present_ff <= dbf_pkg::PRESENT_RST;
            halt_ff <= dbf_pkg::HALT_RST;
            core_rst_n_ff <= 1'b0;
            own_tms_ff <= 1'b0;
            own_tdi_ff <= 1'b0;
            own_tdo_ff <= 1'b0;
            trace_route_ff <= 1'b0;
            fmt_ff <= dbf_pkg::TRACE_FMT_RST_NRZ; // RULE16
            restore_ff <= 1'b0;
            system_rc_clock_ff <= 1'b1;
            keep_ff <= 1'b0;
        end else begin
            tck_q_ff <= tck_st;
            rst_q_ff <= rst_st;
            present_ff <= nxt_present;
            halt_ff <= nxt_halt;
            core_rst_n_ff <= nxt_core_rst_n;
            own_tms_ff <= nxt_own_tms;
            own_tdi_ff <= nxt_own_tdi;
            own_tdo_ff <= nxt_own_tdo;
            trace_route_ff <= nxt_trace_route;
            fmt_ff <= nxt_fmt;
            restore_ff <= nxt_restore;
            system_rc_clock_ff <= nxt_system_rc_clock;
            keep_ff <= nxt_keep;
        end
    end

    // pad muxes stay combinational so probe data is not retimed to sys_clk
    assign tms_pad_o = own_tms_ff ? dp_swdio_o : gpio_tms_o; // RULE4
    assign tms_pad_oe = own_tms_ff ? (swd_s && dp_swdio_oe) : gpio_tms_oe;
    assign tdi_pad_o = gpio_tdi_o;
    assign tdi_pad_oe = own_tdi_ff ? 1'b0 : gpio_tdi_oe;
    assign dp_tdi = own_tdi_ff ? tdi_pad_i : 1'b1;
    assign tdo_pad_o = own_tdo_ff ? (trace_route_ff ? trace_bit : dp_tdo) : gpio_tdo_o;
    assign tdo_pad_oe = own_tdo_ff ? (trace_route_ff || dp_tdo_oe) : gpio_tdo_oe; // RULE7

    assign dbg_present = present_ff;
    assign core_rst_n = core_rst_n_ff;
    assign trace_fmt_nrz = fmt_ff;
    assign cpu_clk_restore = restore_ff;
    assign cpu_clk_system_rc_clock = system_rc_clock_ff;
    assign power_keep = keep_ff;

    chk_present_sticky: assert property ( // RULE19
        @(posedge sys_clk) disable iff (!arst_n)
        present_ff |=> present_ff)
        else $error("debugger present flag dropped");

    chk_detect_on_fall: assert property ( // RULE3
        @(posedge sys_clk) disable iff (!arst_n)
        (tck_fall && rst_st && !backup_mode) |=> present_ff && own_tms_ff)
        else $error("tck falling edge not detected");

    chk_no_detect_reset: assert property ( // RULE19
        @(posedge sys_clk) disable iff (!arst_n)
        (!present_ff && !rst_st) |=> !present_ff)
        else $error("detection during external reset");

    chk_backup_block: assert property ( // RULE15
        @(posedge sys_clk) disable iff (!arst_n)
        (!present_ff && backup_mode) |=> !present_ff)
        else $error("detection in backup mode");

    chk_gpio_default: assert property ( // RULE2
        @(posedge sys_clk) disable iff (!arst_n)
        !present_ff |-> !own_tms_ff && !own_tdi_ff && !own_tdo_ff)
        else $error("debug pins taken without a debugger");

    chk_swd_frees_pins: assert property ( // RULE6
        @(posedge sys_clk) disable iff (!arst_n)
        (present_ff && swd_s) |=> !own_tdi_ff && (own_tdo_ff == $past(trace_en)))
        else $error("serial-wire mode did not free pins");

    chk_trace_on_tdo: assert property ( // RULE7
        @(posedge sys_clk) disable iff (!arst_n)
        (present_ff && !swd_s) |=> !trace_route_ff && own_tdo_ff)
        else $error("trace routed in jtag mode");

    chk_halt_holds: assert property ( // RULE10
        @(posedge sys_clk) disable iff (!arst_n)
        (rst_rel && !tck_st) ##1 !core_rst_release [*2] |-> !core_rst_n_ff)
        else $error("core left reset while halt armed");

    chk_system_rc_clock_in_reset: assert property ( // RULE13
        @(posedge sys_clk) disable iff (!arst_n)
        !rst_st |=> cpu_clk_system_rc_clock && !core_rst_n_ff)
        else $error("cpu not on rc clock during reset");

    chk_power_kept: assert property ( // RULE14
        @(posedge sys_clk) disable iff (!arst_n)
        $rose(present_ff) |-> power_keep ##1 power_keep)
        else $error("power keep not raised with debugger");
endmodule : dbf_front_end

// *** bench/dbf_probe.sv ***
// dbf_probe: behavioural debug probe facing the front end.
// assumes: the bench calls one task at a time; tck idles high between frames.
`timescale 1ns/1ps
module dbf_probe (
    // probe driven pins
    output logic tck,
    output logic tms,
    output logic rst_pin_n
);
    localparam int HALF = 6;
    // frames start off the system clock edges; the two clocks share no phase
    localparam real PHASE = 1.3;

    initial begin
        tck = 1'b1;
        tms = 1'b1;
        rst_pin_n = 1'b1;
    end

    // one tck period, mode-select launched after the falling edge
    task automatic tick(input logic v);
        tck = 1'b0;
        tms = v;
        #(HALF);
        tck = 1'b1;
        #(HALF);
    endtask : tick

    task automatic run_high(input int n);
        for (int i = 0; i < n; i++) begin
            tick(1'b1);
        end
    endtask : run_high

    // slow first edge so the sampled tck level settles, then reach tlr
    task automatic attach();
        #(PHASE);
        tck = 1'b1;
        #40;
        tck = 1'b0;
        #40;
        tck = 1'b1;
        #40;
        run_high(5);
    endtask : attach

    // long high run, code msb first, long high run
    task automatic select(input logic [15:0] code);
        #(PHASE);
        run_high(52);
        for (int i = 15; i >= 0; i--) begin
            tick(code[i]);
        end
        run_high(52);
        // released line must not keep a stale level
        tms = ~tms;
    endtask : select

    task automatic park(input logic t, input logic r);
        tck = t;
        rst_pin_n = r;
    endtask : park
endmodule : dbf_probe

// *** bench/test_debug_port_hot_plug_front_end.sv ***
// test_debug_port_hot_plug_front_end: self-checking bench for the debug front end.
// assumes: dbf_probe stands in for the external probe on tck, mode-select and reset.
`timescale 1ns/1ps
module test_debug_port_hot_plug_front_end;
    logic sys_clk, arst_n, tck, rst_pin_n, probe_tms, tms_pad_i, tdi_pad_i;
    logic tms_pad_o, tms_pad_oe, tdi_pad_o, tdi_pad_oe, tdo_pad_o, tdo_pad_oe;
    logic gpio_tms_o, gpio_tms_oe, gpio_tdi_o, gpio_tdi_oe, gpio_tdo_o, gpio_tdo_oe;
    logic dp_tdo, dp_tdo_oe, dp_swdio_o, dp_swdio_oe, dp_ap_access;
    logic dp_tdi, dp_sync_rst, dp_swd_mode;
    dbf_pkg::dbf_tap_state_t dp_tap_state;
    logic trace_bit, trace_en, trace_fmt_wr, trace_fmt_nrz_req, trace_fmt_nrz;
    logic backup_mode, core_rst_release, dbg_present, core_rst_n;
    logic cpu_clk_restore, cpu_clk_system_rc_clock, power_keep;
    logic [15:0] codes [4];
    int fails, samples_checked, seed;
    // reference model state
    bit m_present, m_swd, m_fmt;

    // pad level seen by the device: its own drive wins while enabled
    assign tms_pad_i = tms_pad_oe ? tms_pad_o : probe_tms;

    dbf_probe probe (.tck(tck), .tms(probe_tms), .rst_pin_n(rst_pin_n));

    // tck reaches only the debug port
    dbf_front_end dut (
        .sys_clk(sys_clk), .arst_n(arst_n), .tck(tck), .rst_pin_n(rst_pin_n),
        .tms_pad_i(tms_pad_i), .tms_pad_o(tms_pad_o), .tms_pad_oe(tms_pad_oe),
        .tdi_pad_i(tdi_pad_i), .tdi_pad_o(tdi_pad_o), .tdi_pad_oe(tdi_pad_oe),
        .tdo_pad_o(tdo_pad_o), .tdo_pad_oe(tdo_pad_oe),
        .gpio_tms_o(gpio_tms_o), .gpio_tms_oe(gpio_tms_oe), .gpio_tdi_o(gpio_tdi_o),
        .gpio_tdi_oe(gpio_tdi_oe), .gpio_tdo_o(gpio_tdo_o), .gpio_tdo_oe(gpio_tdo_oe),
        .dp_tdo(dp_tdo), .dp_tdo_oe(dp_tdo_oe), .dp_swdio_o(dp_swdio_o),
        .dp_swdio_oe(dp_swdio_oe), .dp_ap_access(dp_ap_access), .dp_tdi(dp_tdi),
        .dp_sync_rst(dp_sync_rst), .dp_swd_mode(dp_swd_mode), .dp_tap_state(dp_tap_state),
        .trace_bit(trace_bit), .trace_en(trace_en), .trace_fmt_wr(trace_fmt_wr),
        .trace_fmt_nrz_req(trace_fmt_nrz_req), .trace_fmt_nrz(trace_fmt_nrz),
        .backup_mode(backup_mode), .core_rst_release(core_rst_release),
        .dbg_present(dbg_present), .core_rst_n(core_rst_n),
        .cpu_clk_restore(cpu_clk_restore), .cpu_clk_system_rc_clock(cpu_clk_system_rc_clock),
        .power_keep(power_keep)
    );

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : cyc

    // fresh random pad and core drive, then every pad against the model
    task automatic check_pads();
        logic own_tdo;
        @(posedge sys_clk);
        {gpio_tms_o, gpio_tms_oe, gpio_tdi_o, gpio_tdi_oe} <= 4'($random(seed));
        {gpio_tdo_o, gpio_tdo_oe, dp_tdo, dp_tdo_oe, dp_swdio_o} <= 5'($random(seed));
        {dp_swdio_oe, tdi_pad_i, trace_bit} <= 3'($random(seed));
        cyc(3);
        // look between edges so no register is caught mid-update
        @(negedge sys_clk);
        own_tdo = m_present && (!m_swd || trace_en);
        chk("dbg_present", dbg_present, m_present);
        chk("power_keep", power_keep, m_present);
        chk("swd_mode", dp_swd_mode, m_swd);
        chk("tms_oe", tms_pad_oe, m_present ? (m_swd & dp_swdio_oe) : gpio_tms_oe);
        if (!m_present) chk("tms_o", tms_pad_o, gpio_tms_o);
        else if (m_swd && dp_swdio_oe) chk("tms_o", tms_pad_o, dp_swdio_o);
        if (m_present && !m_swd) chk("tdi_oe", tdi_pad_oe, 1'b0);
        else chk("tdi_pad", {tdi_pad_o, tdi_pad_oe}, {gpio_tdi_o, gpio_tdi_oe});
        chk("dp_tdi", dp_tdi, (m_present && !m_swd) ? tdi_pad_i : 1'b1);
        if (!own_tdo) chk("tdo_pad", {tdo_pad_o, tdo_pad_oe}, {gpio_tdo_o, gpio_tdo_oe});
        else if (!m_swd) chk("tdo_pad", {tdo_pad_o, tdo_pad_oe}, {dp_tdo, dp_tdo_oe});
        else chk("trace_out", tdo_pad_o, trace_bit);
        // the core may not fight the probe on mode-select during frames
        @(posedge sys_clk);
        dp_swdio_oe <= 1'b0;
    endtask : check_pads

    initial begin
        seed = 32'hedcc;
        fails = 0;
        samples_checked = 0;
        {m_present, m_swd, m_fmt} = 3'h0;
        {arst_n, tdi_pad_i, gpio_tms_o, gpio_tms_oe, gpio_tdi_o, gpio_tdi_oe} = 6'h00;
        {gpio_tdo_o, gpio_tdo_oe, dp_tdo, dp_tdo_oe, dp_swdio_o, dp_swdio_oe} = 6'h00;
        {dp_ap_access, trace_bit, trace_en, trace_fmt_wr, trace_fmt_nrz_req} = 5'h00;
        {backup_mode, core_rst_release} = 2'h0;
        codes = '{16'h79e7, 16'h79e6, 16'h3ce7, 16'h79e7};
        cyc(10);
        arst_n <= 1'b1;
        cyc(10);
        chk("trace_fmt", trace_fmt_nrz, 1'b0);
        chk("sync_rst", dp_sync_rst, 1'b1);
        chk("core_rst_n", core_rst_n, 1'b1);
        check_pads();
        backup_mode <= 1'b1;
        probe.attach();
        check_pads();
        backup_mode <= 1'b0;
        probe.attach();
        m_present = 1'b1;
        check_pads();
        chk("core_rst_n", core_rst_n, 1'b1);
        chk("tap", dp_tap_state, dbf_pkg::ST_TLR);
        probe.tick(1'b0);
        cyc(2);
        chk("tap", dp_tap_state, dbf_pkg::ST_RTI);
        chk("sync_rst", dp_sync_rst, 1'b0);
        probe.run_high(5);
        cyc(2);
        chk("sync_rst", dp_sync_rst, 1'b1);
        for (int i = 0; i < 4; i++) begin
            m_fmt = (i % 2 == 0);
            @(posedge sys_clk);
            trace_fmt_wr <= 1'b1;
            trace_fmt_nrz_req <= m_fmt;
            @(posedge sys_clk);
            trace_fmt_wr <= 1'b0;
            trace_fmt_nrz_req <= !m_fmt;
            cyc(2);
            chk("trace_fmt", trace_fmt_nrz, m_fmt);
        end
        // swd, near-miss code, back to jtag, swd again; trace wanted on odd steps
        for (int i = 0; i < 4; i++) begin
            trace_en <= i[0];
            probe.select(codes[i]);
            if (codes[i] == 16'h79e7) m_swd = 1'b1;
            else if (codes[i] == 16'h3ce7) m_swd = 1'b0;
            cyc(8);
            check_pads();
        end
        dp_ap_access <= 1'b1;
        cyc(8);
        chk("clk_restore", cpu_clk_restore, 1'b1);
        dp_ap_access <= 1'b0;
        cyc(8);
        chk("clk_restore", cpu_clk_restore, 1'b0);
        // second reset with the probe holding tck low for a core halt
        arst_n <= 1'b0;
        probe.park(1'b0, 1'b0);
        {m_present, m_swd} = 2'h0;
        cyc(10);
        arst_n <= 1'b1;
        cyc(10);
        chk("dbg_present", dbg_present, 1'b0);
        chk("system_rc_clock", cpu_clk_system_rc_clock, 1'b1);
        probe.park(1'b0, 1'b1);
        cyc(10);
        chk("core_rst_n", core_rst_n, 1'b0);
        chk("system_rc_clock", cpu_clk_system_rc_clock, 1'b0);
        probe.attach();
        m_present = 1'b1;
        check_pads();
        chk("core_rst_n", core_rst_n, 1'b0);
        core_rst_release <= 1'b1;
        @(posedge sys_clk);
        core_rst_release <= 1'b0;
        cyc(3);
        chk("core_rst_n", core_rst_n, 1'b1);
        test_done();
    end

    // whole run is some 7 us; about four times that means a hang
    initial begin
        #30000;
        fails++;
        test_done();
    end
endmodule : test_debug_port_hot_plug_front_end
